// ===== verilog/acs_sequencer.sv
// Conversion sequencer with APB register slave, result formatting and byte interlock.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"

// What this block does
// - Status-control write starts a new conversion.
// - Conversion lasts sixteen to seventeen converter clocks.
// - High reference gives 3FF, low gives 000.
// - Continuous mode overwrites unread results.
// - Continuous mode repeats until its bit clears.
// - Done flag set per conversion, cleared by read.
// - Single mode converts once per write.
// - Two-bit justify field selects four layouts.
// - Codes trunc, right, left, signed; reset right.
// - Left mode: eight MSBs high, two LSBs low.
// - Two-byte modes hold results from high read until low read.
// - High read freezes low byte until read.
// - Right mode: two MSBs high, eight low.
// - Signed left mode inverts result bit nine.
// - Truncation: eight MSBs in low, no interlock.
// - Interrupt per conversion; done flag reads zero.
// - Data read or control write clears interrupt.
// - Runs in wait mode; interrupt wakes processor.
// - All-ones channel field switches converter off.
// - Stop mode aborts conversion, goes inactive.
// - Stop exit resumes conversion without new start.
module acs_sequencer (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	// Converter clock sources, asynchronous to mclk.
	input  wire logic        osc_clk_in,
	input  wire logic        bus_clk_in,
	// Analog core: sampled 10-bit code and selected channel.
	input  wire logic [9:0]  analog_code,
	output var  logic [4:0]  channel_sel,
	output var  logic        conv_power_on,
	// Processor power modes and interrupt.
	input  wire logic        stop_mode,
	input  wire logic        wait_mode,
	output var  logic        conv_irq,
	output var  logic        wake_req
);
	// Control registers.
	logic [4:0] channel_select_field;
	logic       continuous_convert_bit;
	logic       conv_irq_enable;
	logic       conversion_done_flag;
	logic [7:0] conv_clock_reg;
	logic [9:0] result;
	logic       low_frozen;
	logic [7:0] low_latch;
	logic       irq_pend;
	logic       pending_start;
	acs_pkg::acs_state_t state;
	logic [4:0] cyc_cnt;
	logic [3:0] div_cnt;
	logic [1:0] osc_sync;
	logic [1:0] bus_sync;
	logic [1:0] stop_sync;
	logic [1:0] wait_sync;
	logic       src_prev;

	// Field views of the clock register.
	wire logic       justify_sel_lo = conv_clock_reg[`ACS_CLK_MODE_LSB];
	wire logic       justify_sel_hi = conv_clock_reg[`ACS_CLK_MODE_LSB + 1];
	wire logic [1:0] justify_sel = {justify_sel_hi, justify_sel_lo};
	wire logic [2:0] conv_clock_prescaler = conv_clock_reg[`ACS_CLK_DIV_LSB +: 3];
	wire logic       conv_clock_source_sel = conv_clock_reg[`ACS_CLK_SRC];

	// Bus decode.
	wire logic acc       = psel & penable;
	wire logic wr        = acc & pwrite;
	wire logic rd        = acc & ~pwrite;
	wire logic hit_scr   = paddr == `ACS_OFF_SCR;
	wire logic hit_rh    = paddr == `ACS_OFF_RH;
	wire logic hit_rl    = paddr == `ACS_OFF_RL;
	wire logic hit_clk   = paddr == `ACS_OFF_CLK;
	wire logic hit_sys   = paddr == `ACS_OFF_SYS;
	wire logic mapped    = hit_scr | hit_rh | hit_rl | hit_clk | hit_sys;
	wire logic wr_scr    = wr & hit_scr;
	wire logic rd_rh     = rd & hit_rh;
	wire logic rd_rl     = rd & hit_rl;
	wire logic rd_data   = rd_rh | rd_rl;
	wire logic off_sel   = channel_select_field == `ACS_CH_OFF;
	wire logic stopped   = stop_sync[1];
	wire logic two_byte  = justify_sel != acs_pkg::ACS_TRUNC8;

	// Prescaler tick: edges of the synchronised source, divided by 1..16.
	wire logic src_lvl   = conv_clock_source_sel ? bus_sync[1] : osc_sync[1];
	wire logic src_edge  = src_lvl & ~src_prev;
	// Sources must stay below half of mclk, or the edge detector misses edges.
	wire logic [3:0] div_max = conv_clock_prescaler[2] ? 4'hF :
		4'((5'h01 << conv_clock_prescaler[1:0]) - 5'h01);
	wire logic conv_tick = src_edge & (div_cnt == div_max);

	// Reference channels give exact end codes; others take the core's code.
	wire logic [9:0] sample = (channel_select_field == `ACS_CH_REFH) ? 10'h3FF :
		(channel_select_field == `ACS_CH_REFL) ? 10'h000 : analog_code;
	wire logic conv_end  = (state == acs_pkg::ACS_CONV) & conv_tick &
		(cyc_cnt == `ACS_CONV_CYCLES - 5'h01);
	// Interlocked results are dropped while the high byte waits for its low partner.
	wire logic store_ok  = ~(two_byte & low_frozen);

	// Formats a 10-bit result into the high or low byte.
	function automatic logic [7:0] fmt(input logic [1:0] m, input logic [9:0] r,
		input logic hi);
		logic [7:0] b;
		b = 8'h00;
		case (m)
			acs_pkg::ACS_TRUNC8: b = hi ? 8'h00 : r[9:2];
			acs_pkg::ACS_RIGHT:  b = hi ? {6'h00, r[9:8]} : r[7:0];
			acs_pkg::ACS_LEFT:   b = hi ? r[9:2] : {r[1:0], 6'h00};
			acs_pkg::ACS_LSIGN:  b = hi ? {~r[9], r[8:2]} : {r[1:0], 6'h00};
			default:             b = 8'h00;
		endcase
		return b;
	endfunction

	wire logic [7:0] high_byte = fmt(justify_sel, result, 1'b1);
	wire logic [7:0] live_low  = fmt(justify_sel, result, 1'b0);
	wire logic [7:0] low_byte  = (two_byte & low_frozen) ? low_latch : live_low;
	wire logic       done_view = conversion_done_flag & ~conv_irq_enable;
	wire logic [7:0] scr_view  = {done_view, conv_irq_enable, continuous_convert_bit,
		channel_select_field};
	wire logic [7:0] rd_byte   = hit_scr ? scr_view : hit_rh ? high_byte :
		hit_rl ? low_byte : hit_clk ? conv_clock_reg :
		hit_sys ? {5'h00, wait_sync[1], stopped, state == acs_pkg::ACS_CONV} : 8'h00;

	// Input synchronisers; only stage one feeds stage two.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			osc_sync  <= 2'h0;
			bus_sync  <= 2'h0;
			stop_sync <= 2'h0;
			wait_sync <= 2'h0;
			src_prev  <= 1'b0;
		end else begin
			osc_sync  <= {osc_sync[0], osc_clk_in};
			bus_sync  <= {bus_sync[0], bus_clk_in};
			stop_sync <= {stop_sync[0], stop_mode};
			wait_sync <= {wait_sync[0], wait_mode};
			src_prev  <= src_lvl;
		end
	end

	// Prescaler counter restarts on a status-control write so timing is repeatable.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) div_cnt <= 4'h0;
		else if (wr_scr | (src_edge & div_cnt >= div_max)) div_cnt <= 4'h0;
		else if (src_edge) div_cnt <= div_cnt + 4'h1;
	end

	// APB answer: zero wait states, unmapped addresses flag an error.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	// Accesses complete on the cycle pready is high.
	wire logic done_acc = acc & pready;
	wire logic wr_go    = wr_scr & pready;
	wire logic rd_go_h  = rd_rh & pready;
	wire logic rd_go_l  = rd_rl & pready;
	wire logic rd_go    = rd_data & pready;

	// Software registers.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			channel_select_field   <= 5'(`ACS_SCR_RESET);
			continuous_convert_bit <= 1'b0;
			conv_irq_enable        <= 1'b0;
			conv_clock_reg         <= `ACS_CLK_RESET;
		end else if (done_acc & pwrite) begin
			if (hit_scr) begin
				channel_select_field   <= pwdata[`ACS_SCR_CH_LSB +: 5];
				continuous_convert_bit <= pwdata[`ACS_SCR_CONT];
				conv_irq_enable        <= pwdata[`ACS_SCR_IEN];
			end
			if (hit_clk) conv_clock_reg <= {pwdata[7:2], 2'h0};
		end
	end

	// Sequencer: a write restarts, stop aborts, stop exit resumes.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state         <= acs_pkg::ACS_IDLE;
			cyc_cnt       <= 5'h00;
			pending_start <= 1'b0;
		end else begin
			case (state)
				acs_pkg::ACS_IDLE: begin
					if (wr_go & ~stopped) begin
						state   <= acs_pkg::ACS_CONV;
						cyc_cnt <= 5'h00;
					end
				end
				acs_pkg::ACS_CONV: begin
					if (stopped) begin
						state         <= acs_pkg::ACS_HALT;
						pending_start <= 1'b1;
					end else if (wr_go) begin
						cyc_cnt <= 5'h00;
					end else if (off_sel) begin
						state <= acs_pkg::ACS_IDLE;
					end else if (conv_end) begin
						cyc_cnt <= 5'h00;
						if (!continuous_convert_bit) state <= acs_pkg::ACS_IDLE;
					end else if (conv_tick) begin
						cyc_cnt <= cyc_cnt + 5'h01;
					end
				end
				acs_pkg::ACS_HALT: begin
					if (!stopped) begin
						state         <= pending_start ? acs_pkg::ACS_CONV : acs_pkg::ACS_IDLE;
						cyc_cnt       <= 5'h00;
						pending_start <= 1'b0;
					end
				end
				default: state <= acs_pkg::ACS_IDLE;
			endcase
		end
	end

	// Result capture; the sample is taken at the last converter cycle.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) result <= 10'h000;
		else if (conv_end & ~wr_go & ~stopped & ~off_sel & store_ok) result <= sample;
	end

	// Interlock: a high read freezes the low byte until the low read.
	// A second high read while frozen must not refresh the latch, or the pair would mix.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_frozen <= 1'b0;
			low_latch  <= 8'h00;
		end else if (rd_go_l) begin
			low_frozen <= 1'b0;
		end else if (rd_go_h & two_byte & ~low_frozen) begin
			low_frozen <= 1'b1;
			low_latch  <= live_low;
		end
	end

	// Done flag and interrupt; a new completion wins over a clearing data read.
	// A result dropped by the interlock still reports completion of its conversion.
	wire logic stored = conv_end & ~wr_go & ~stopped & ~off_sel;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			conversion_done_flag <= 1'b0;
			irq_pend             <= 1'b0;
		end else begin
			conversion_done_flag <= (stored & ~conv_irq_enable) |
				(conversion_done_flag & ~rd_go);
			irq_pend <= (stored & conv_irq_enable) |
				(irq_pend & conv_irq_enable & ~(rd_go | wr_go));
		end
	end

	// Outputs, all registered.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			conv_irq      <= 1'b0;
			wake_req      <= 1'b0;
			channel_sel   <= 5'(`ACS_SCR_RESET);
			conv_power_on <= 1'b0;
		end else begin
			conv_irq      <= irq_pend;
			wake_req      <= irq_pend & wait_sync[1];
			channel_sel   <= channel_select_field;
			conv_power_on <= ~off_sel & ~stopped;
		end
	end

	// Checks.
	sequence s_start;
		wr_go & ~stopped & ~off_sel;
	endsequence
	a_start_conv: assert property (@(posedge mclk) disable iff (!arst_n)
		s_start |=> state == acs_pkg::ACS_CONV) else $error("start not taken");
	a_end_count: assert property (@(posedge mclk) disable iff (!arst_n)
		conv_end |-> cyc_cnt == 5'h10) else $error("wrong conversion length");
	a_done_set: assert property (@(posedge mclk) disable iff (!arst_n)
		stored & ~conv_irq_enable |=> conversion_done_flag) else $error("done not set");
	a_irq_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_go & ~stored |=> ~irq_pend) else $error("irq not cleared");
	a_single_idle: assert property (@(posedge mclk) disable iff (!arst_n)
		conv_end & ~continuous_convert_bit & ~wr_go & ~stopped & ~off_sel
		|=> state == acs_pkg::ACS_IDLE) else $error("single mode kept running");
	a_cont_run: assert property (@(posedge mclk) disable iff (!arst_n)
		conv_end & continuous_convert_bit & ~stopped & ~off_sel
		|=> state == acs_pkg::ACS_CONV) else $error("continuous mode stopped");
	a_stop_abort: assert property (@(posedge mclk) disable iff (!arst_n)
		stopped & state == acs_pkg::ACS_CONV |=> state == acs_pkg::ACS_HALT)
		else $error("stop did not abort");
	a_resume_stop: assert property (@(posedge mclk) disable iff (!arst_n)
		state == acs_pkg::ACS_HALT & ~stopped |=> state == acs_pkg::ACS_CONV)
		else $error("no resume after stop");
	a_freeze_low: assert property (@(posedge mclk) disable iff (!arst_n)
		low_frozen & ~rd_go_l |=> $stable(low_latch)) else $error("low byte moved");
	a_done_masked: assert property (@(posedge mclk) disable iff (!arst_n)
		done_acc & ~pwrite & hit_scr & conv_irq_enable |-> ~prdata[`ACS_SCR_DONE])
		else $error("done visible with irq");
	a_off_power: assert property (@(posedge mclk) disable iff (!arst_n)
		off_sel |=> ~conv_power_on) else $error("power not off");
	// An interrupt-mode completion must raise the request on the next cycle.
	a_irq_set: assert property (@(posedge mclk) disable iff (!arst_n)
		stored & conv_irq_enable |=> irq_pend) else $error("irq not raised");
	sequence s_free_store;
		~two_byte & conv_end & ~wr_go & ~stopped & ~off_sel;
	endsequence
	a_store_free: assert property (@(posedge mclk) disable iff (!arst_n)
		s_free_store |=> result == $past(sample)) else $error("result not stored");
	a_wake_wait: assert property (@(posedge mclk) disable iff (!arst_n)
		irq_pend & wait_sync[1] |=> wake_req) else $error("no wake request");
	a_stop_power: assert property (@(posedge mclk) disable iff (!arst_n)
		stopped |=> ~conv_power_on) else $error("power on in stop");
	a_halt_pend: assert property (@(posedge mclk) disable iff (!arst_n)
		state == acs_pkg::ACS_HALT |-> pending_start) else $error("no pending start");
endmodule // acs_sequencer
`default_nettype wire

// ===== verilog/acs_cfg.svh
// Register offsets, field positions, reset values and timing counts of the conversion sequencer.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_OFF_SCR      12'h000
`define ACS_OFF_RH       12'h004
`define ACS_OFF_RL       12'h008
`define ACS_OFF_CLK      12'h00C
`define ACS_OFF_SYS      12'h010
`define ACS_SCR_CH_LSB   0
`define ACS_SCR_CONT     5
`define ACS_SCR_IEN      6
`define ACS_SCR_DONE     7
`define ACS_CLK_SRC      4
`define ACS_CLK_MODE_LSB 2
`define ACS_CLK_DIV_LSB  5
`define ACS_SCR_RESET    8'h1F
`define ACS_CLK_RESET    8'h04
`define ACS_CH_OFF       5'h1F
`define ACS_CH_REFH      5'h1D
`define ACS_CH_REFL      5'h1E
`define ACS_CONV_CYCLES  5'h11
`define ACS_SAMPLE_CYCLE 5'h10
`endif

// ===== verilog/acs_pkg.sv
// Types shared by the conversion sequencer.
`default_nettype none
package acs_pkg;
	typedef enum logic [1:0] {
		ACS_TRUNC8 = 2'h0,
		ACS_RIGHT  = 2'h1,
		ACS_LEFT   = 2'h2,
		ACS_LSIGN  = 2'h3
	} acs_justify_t;
	typedef enum logic [2:0] {
		ACS_IDLE = 3'h1,
		ACS_CONV = 3'h2,
		ACS_HALT = 3'h4
	} acs_state_t;
endpackage
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench for the conversion sequencer, driven over APB.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
module tb_top;
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        osc_clk_in, bus_clk_in, conv_power_on, stop_mode, wait_mode, conv_irq, wake_req;
	logic [9:0]  analog_code;
	logic [4:0]  channel_sel, src_cnt;
	logic        rerr;
	int          n_errors, check_count, cyc;

	acs_sequencer acs_sequencer_i (.mclk(mclk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .osc_clk_in(osc_clk_in),
		.bus_clk_in(bus_clk_in), .analog_code(analog_code), .channel_sel(channel_sel),
		.conv_power_on(conv_power_on), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.conv_irq(conv_irq), .wake_req(wake_req));

	// System clock of 50 MHz.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Converter sources: oscillator at a sixth and bus clock at an eighth of mclk.
	always @(posedge mclk) begin
		if (!arst_n) begin
			src_cnt <= 5'h00;
			osc_clk_in <= 1'b0;
			bus_clk_in <= 1'b0;
		end else begin
			src_cnt <= (src_cnt == 5'h17) ? 5'h00 : src_cnt + 5'h01;
			osc_clk_in <= (src_cnt % 5'h06) < 5'h03;
			bus_clk_in <= (src_cnt % 5'h08) < 5'h04;
		end
	end

	// Counts and compares one result.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready_seen", 32'h1, {31'h0, n < 50});
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask

	// Polls the done flag with a bounded number of reads.
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			apb(1'b0, `ACS_OFF_SCR, 32'h0);
			n++;
		end while (rdat[7] !== 1'b1 && n < 400);
		chk("done_set", 32'h1, {31'h0, rdat[7]});
	endtask

	// Starts an interrupt-mode conversion and checks its length for a tick of t cycles.
	// The window allows one extra tick plus synchroniser delay on top of 16 to 17 ticks.
	task automatic tconv(input int t);
		wr(`ACS_OFF_SCR, 32'h40);
		cyc = 0;
		while (conv_irq !== 1'b1 && cyc < 2000) begin
			@(posedge mclk);
			cyc++;
		end
		chk("conv_time", 32'h1, {31'h0, cyc >= 16 * t - t && cyc <= 18 * t + 8});
	endtask

	function automatic logic [31:0] ehi(input int m, input logic [9:0] c);
		case (m)
			0: ehi = 32'h0;
			1: ehi = {30'h0, c[9:8]};
			2: ehi = {24'h0, c[9:2]};
			default: ehi = {24'h0, ~c[9], c[8:2]};
		endcase
	endfunction

	function automatic logic [31:0] elo(input int m, input logic [9:0] c);
		elo = (m == 0) ? {24'h0, c[9:2]} : (m == 1) ? {24'h0, c[7:0]} : {24'h0, c[1:0], 6'h0};
	endfunction

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		stop_test();
	end

	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata, stop_mode, wait_mode} = '0;
		{analog_code, n_errors, check_count} = '0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk("chan_rst", 32'h1F, {27'h0, channel_sel});
		chk("power_rst", 32'h0, {31'h0, conv_power_on});
		rchk("scr_rst", `ACS_OFF_SCR, 32'h1F);
		rchk("clk_rst", `ACS_OFF_CLK, 32'h04);
		apb(1'b0, 12'h0F0, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, rerr});
		// Every justification code on one input value.
		analog_code <= 10'h2B5;
		for (int m = 0; m < 4; m++) begin
			wr(`ACS_OFF_CLK, m << 2);
			wr(`ACS_OFF_SCR, 32'h00);
			wait_done();
			rchk("high_byte", `ACS_OFF_RH, ehi(m, 10'h2B5));
			rchk("low_byte", `ACS_OFF_RL, elo(m, 10'h2B5));
			rchk("done_clear", `ACS_OFF_SCR, 32'h00);
		end
		// Single mode stays idle after its one conversion.
		repeat (300) @(posedge mclk);
		rchk("single_idle", `ACS_OFF_SCR, 32'h00);
		// Reference channels, right justified.
		wr(`ACS_OFF_CLK, 32'h04);
		wr(`ACS_OFF_SCR, 32'h1D);
		wait_done();
		rchk("refh_hi", `ACS_OFF_RH, 32'h03);
		rchk("refh_lo", `ACS_OFF_RL, 32'hFF);
		wr(`ACS_OFF_SCR, 32'h1E);
		wait_done();
		rchk("refl_hi", `ACS_OFF_RH, 32'h00);
		rchk("refl_lo", `ACS_OFF_RL, 32'h00);
		// Left justified: a high-byte read freezes the low byte and blocks new results.
		wr(`ACS_OFF_CLK, 32'h08);
		wr(`ACS_OFF_SCR, 32'h00);
		wait_done();
		rchk("lock_hi", `ACS_OFF_RH, 32'hAD);
		analog_code <= 10'h0CA;
		wr(`ACS_OFF_SCR, 32'h00);
		repeat (300) @(posedge mclk);
		rchk("lock_lo", `ACS_OFF_RL, 32'h40);
		wr(`ACS_OFF_SCR, 32'h00);
		wait_done();
		rchk("unlock_hi", `ACS_OFF_RH, 32'h32);
		// Truncation has no interlock.
		wr(`ACS_OFF_CLK, 32'h00);
		analog_code <= 10'h2B5;
		wr(`ACS_OFF_SCR, 32'h00);
		wait_done();
		rchk("trunc_hi", `ACS_OFF_RH, 32'h00);
		analog_code <= 10'h0CA;
		wr(`ACS_OFF_SCR, 32'h00);
		wait_done();
		rchk("trunc_lo", `ACS_OFF_RL, 32'h32);
		// Continuous mode overwrites unread data and keeps going.
		wr(`ACS_OFF_CLK, 32'h04);
		analog_code <= 10'h111;
		wr(`ACS_OFF_SCR, 32'h20);
		wait_done();
		analog_code <= 10'h222;
		repeat (300) @(posedge mclk);
		rchk("overwrite", `ACS_OFF_RL, 32'h22);
		wait_done();
		rchk("cont_next", `ACS_OFF_RL, 32'h22);
		wr(`ACS_OFF_SCR, 32'h00);
		wait_done();
		rchk("cont_last", `ACS_OFF_RL, 32'h22);
		repeat (300) @(posedge mclk);
		rchk("cont_off", `ACS_OFF_SCR, 32'h00);
		// Interrupt mode, with the processor waiting.
		wait_mode <= 1'b1;
		tconv(6);
		chk("wake", 32'h1, {31'h0, wake_req});
		rchk("done_masked", `ACS_OFF_SCR, 32'h40);
		rchk("irq_data", `ACS_OFF_RL, 32'h22);
		repeat (2) @(posedge mclk);
		chk("irq_rd_clr", 32'h0, {31'h0, conv_irq});
		wr(`ACS_OFF_CLK, 32'h34);
		tconv(16);
		// Interrupt enable stays set, so only the write itself can clear the request.
		wr(`ACS_OFF_SCR, 32'h5F);
		repeat (4) @(posedge mclk);
		chk("irq_wr_clr", 32'h0, {31'h0, conv_irq});
		chk("power_off", 32'h0, {31'h0, conv_power_on});
		// Stop mode aborts a conversion and resumes it on exit.
		wait_mode <= 1'b0;
		wr(`ACS_OFF_CLK, 32'h04);
		wr(`ACS_OFF_SCR, 32'h00);
		repeat (30) @(posedge mclk);
		stop_mode <= 1'b1;
		repeat (300) @(posedge mclk);
		chk("stop_power", 32'h0, {31'h0, conv_power_on});
		rchk("stop_nodone", `ACS_OFF_SCR, 32'h00);
		rchk("stop_status", `ACS_OFF_SYS, 32'h02);
		stop_mode <= 1'b0;
		wait_done();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
